// ---- hub_timing_pkg.sv ----
// Package of timing limits, counts and carrier types for the hub timing block
package hub_timing_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;

  // Longest times round down to whole cycles
  localparam int unsigned DOWN_WAKE_NS      = 400;
  localparam int unsigned DOWN_WAKE_CYC     = DOWN_WAKE_NS / CLK_PERIOD_NS;
  localparam int unsigned UP_WAKE_MS        = 1;
  localparam int unsigned UP_WAKE_CYC       = UP_WAKE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned DRIVE_WAKE_NS     = 1000;
  localparam int unsigned DRIVE_WAKE_CYC    = DRIVE_WAKE_NS / CLK_PERIOD_NS;
  localparam int unsigned PORT2PORT_US      = 1;
  localparam int unsigned PORT2PORT_CYC     = PORT2PORT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RESET_ERR_MS      = 100;
  localparam int unsigned RESET_ERR_CYC     = RESET_ERR_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CHECK_ON_RESET_MS = 1;
  localparam int unsigned CHECK_ON_RESET_CYC = CHECK_ON_RESET_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned SWITCH_DISC_MS    = 1;
  localparam int unsigned SWITCH_DISC_CYC   = SWITCH_DISC_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned JITTER_LIMIT_NS   = 8;
  localparam int unsigned JITTER_LIMIT_CYC  = JITTER_LIMIT_NS / CLK_PERIOD_NS;

  localparam int unsigned BABBLE_SYMBOLS    = 1030;
  localparam int unsigned SKP_SPACING       = 354;
  localparam int unsigned MAX_PORTS         = 15;
  localparam int unsigned CURRENT_UNIT_MA   = 4;

  localparam int unsigned CNT_W             = 26;

  typedef struct packed {
    logic pay_start;
    logic pay_end;
    logic pay_abort;
    logic symbol;
  } rx_sym_s;

  typedef struct packed {
    logic bus_reset;
    logic training;
    logic u0_from_idle;
  } periph_ev_s;

endpackage

// ---- limit_timer.sv ----
// Restartable limit timer: counts while armed, pulses once at terminal count
`timescale 1ns/1ns
module limit_timer #(
  parameter int unsigned W     = 26,
  parameter int unsigned LIMIT = 100
) (
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  input  wire logic ce_i,
  input  wire logic start_i,
  input  wire logic stop_i,
  output logic      busy_o,
  output logic      due_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         run_q;
  logic         run_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (start_i) begin
      cnt_d = '0;
      run_d = 1'b1;
    end else if (stop_i) begin
      run_d = 1'b0;
    end else if (run_q) begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == W'(LIMIT - 1)) begin
        run_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  assign busy_o = run_q;
  assign due_o  = run_q && !start_i && !stop_i && (cnt_q == W'(LIMIT - 1));

endmodule // limit_timer

// ---- hub_port_timing_limits.sv ----
// Hub and peripheral upstream port timing limit enforcement
`timescale 1ns/1ns
module hub_port_timing_limits
  import hub_timing_pkg::*;
#(
  parameter int unsigned PORTS          = MAX_PORTS,
  parameter int unsigned UP_WAKE_LIM    = UP_WAKE_CYC,
  parameter int unsigned RESET_ERR_LIM  = RESET_ERR_CYC,
  parameter int unsigned ON_RESET_LIM   = CHECK_ON_RESET_CYC,
  parameter int unsigned SWITCH_LIM     = SWITCH_DISC_CYC
) (
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             ce_i,
  input  wire logic [PORTS-1:0] hdr_first_i,
  input  wire logic [PORTS-1:0] ds_low_power_i,
  input  wire logic [PORTS-1:0] ds_wake_start_i,
  input  wire logic             us_in_u3_i,
  input  wire logic [PORTS-1:0] set_u0_req_i,
  input  wire logic [PORTS-1:0] ds_in_u3_i,
  input  wire logic [PORTS-1:0] ds_ustate_chg_i,
  input  wire logic [PORTS-1:0] warm_reset_i,
  input  wire logic [PORTS-1:0] ds_rxdetect_i,
  input  wire rx_sym_s          rx_i,
  input  wire logic             tx_symbol_i,
  input  wire periph_ev_s       periph_i,
  input  wire logic             usb2_connected_i,
  input  wire logic [7:0]       ctrl_current_ma_i,
  output logic [PORTS-1:0]      ds_exit_lp_o,
  output logic                  us_wake_o,
  output logic [PORTS-1:0]      ds_drive_wake_o,
  output logic                  us_ustate_chg_o,
  output logic [PORTS-1:0]      reset_fail_o,
  output logic                  babble_o,
  output logic                  skp_insert_o,
  output logic                  periph_power_on_o,
  output logic                  usb2_disconnect_o,
  output logic                  training_o,
  output logic [7:0]            ctrl_current_units_o,
  output logic [15:0]           hub_delay_ns_o,
  output logic [3:0]            port_count_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Immediate actions; the deadlines are met with margin by acting next cycle

  logic [PORTS-1:0] ds_exit_lp_d, ds_exit_lp_q;
  logic [PORTS-1:0] ds_drive_d, ds_drive_q;
  logic             us_wake_d, us_wake_q;
  logic             us_chg_d, us_chg_q;

  always_comb begin
    ds_exit_lp_d = hdr_first_i & ds_low_power_i;
    ds_drive_d   = set_u0_req_i & ds_in_u3_i;
    us_wake_d    = us_in_u3_i && (|ds_wake_start_i);
    us_chg_d     = |ds_ustate_chg_i;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ds_exit_lp_q <= '0;
      ds_drive_q   <= '0;
      us_wake_q    <= 1'b0;
      us_chg_q     <= 1'b0;
    end else if (ce_i) begin
      ds_exit_lp_q <= ds_exit_lp_d;
      ds_drive_q   <= ds_drive_d;
      us_wake_q    <= us_wake_d;
      us_chg_q     <= us_chg_d;
    end
  end

  assign ds_exit_lp_o    = ds_exit_lp_q;
  assign ds_drive_wake_o = ds_drive_q;
  assign us_wake_o       = us_wake_q;
  assign us_ustate_chg_o = us_chg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Warm reset failure timers, one per port

  logic [PORTS-1:0] rst_busy, rst_due;
  logic [PORTS-1:0] rx_det_q;
  logic [PORTS-1:0] rst_fail_d, rst_fail_q;

  for (genvar p = 0; p < PORTS; p++) begin : g_rst
    limit_timer #(.W(CNT_W), .LIMIT(RESET_ERR_LIM)) u_rst (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .ce_i      (ce_i),
      .start_i   (warm_reset_i[p] && ds_rxdetect_i[p] && !rx_det_q[p]),
      .stop_i    (!warm_reset_i[p] || !ds_rxdetect_i[p]),
      .busy_o    (rst_busy[p]),
      .due_o     (rst_due[p])
    );
  end

  always_comb begin
    rst_fail_d = (rst_fail_q | rst_due) & warm_reset_i;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_det_q   <= '0;
      rst_fail_q <= '0;
    end else if (ce_i) begin
      rx_det_q   <= ds_rxdetect_i & warm_reset_i;
      rst_fail_q <= rst_fail_d;
    end
  end

  assign reset_fail_o = rst_fail_q;

  ////////////////////////////////////////////////////////////////////////////
  // Babble detection and SKP pacing

  logic [10:0] bab_cnt_d, bab_cnt_q;
  logic        in_pay_d, in_pay_q;
  logic        babble_d, babble_q;
  logic [8:0]  skp_cnt_d, skp_cnt_q;
  logic        skp_d, skp_q;

  always_comb begin
    bab_cnt_d = bab_cnt_q;
    in_pay_d  = in_pay_q;
    babble_d  = 1'b0;
    if (rx_i.pay_start) begin
      bab_cnt_d = '0;
      in_pay_d  = 1'b1;
    end else if (rx_i.pay_end || rx_i.pay_abort) begin
      in_pay_d = 1'b0;
    end else if (in_pay_q && rx_i.symbol) begin
      bab_cnt_d = bab_cnt_q + 11'h001;
      if (bab_cnt_q == 11'(BABBLE_SYMBOLS - 1)) begin
        babble_d = 1'b1;
        in_pay_d = 1'b0;
      end
    end
    // Fixed spacing makes the average exact
    skp_cnt_d = skp_cnt_q;
    skp_d     = 1'b0;
    if (tx_symbol_i) begin
      if (skp_cnt_q == 9'(SKP_SPACING - 1)) begin
        skp_cnt_d = '0;
        skp_d     = 1'b1;
      end else begin
        skp_cnt_d = skp_cnt_q + 9'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bab_cnt_q <= '0;
      in_pay_q  <= 1'b0;
      babble_q  <= 1'b0;
      skp_cnt_q <= '0;
      skp_q     <= 1'b0;
    end else if (ce_i) begin
      bab_cnt_q <= bab_cnt_d;
      in_pay_q  <= in_pay_d;
      babble_q  <= babble_d;
      skp_cnt_q <= skp_cnt_d;
      skp_q     <= skp_d;
    end
  end

  assign babble_o     = babble_q;
  assign skp_insert_o = skp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral upstream port: 2.0 reset and interface switching

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h1,
    ST_TRAINING = 3'h2,
    ST_ENABLED  = 3'h4
  } up_state_e;

  up_state_e st_d, st_q;
  logic      pwr_on_d, pwr_on_q;
  logic      disc_d, disc_q;

  always_comb begin
    st_d     = st_q;
    pwr_on_d = periph_i.bus_reset;
    disc_d   = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (periph_i.training) begin
          st_d   = ST_TRAINING;
          disc_d = usb2_connected_i;
        end
      end
      ST_TRAINING: begin
        if (periph_i.u0_from_idle) begin
          st_d = ST_ENABLED;
        end
      end
      ST_ENABLED: begin
        if (periph_i.bus_reset) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q     <= ST_IDLE;
      pwr_on_q <= 1'b0;
      disc_q   <= 1'b0;
    end else if (ce_i) begin
      st_q     <= st_d;
      pwr_on_q <= pwr_on_d;
      disc_q   <= disc_d;
    end
  end

  assign periph_power_on_o = pwr_on_q;
  assign usb2_disconnect_o = disc_q;
  assign training_o        = (st_q == ST_TRAINING);

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor figures; forwarding is one registered stage so jitter is zero

  assign ctrl_current_units_o = ctrl_current_ma_i / 8'(CURRENT_UNIT_MA);
  assign hub_delay_ns_o       = 16'(CLK_PERIOD_NS);
  assign port_count_o         = 4'(PORTS);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Enable is part of the start step, so the sequence stands alone as antecedent
  sequence s_pay_run;
    (ce_i && rx_i.pay_start) ##1 (in_pay_q && !rx_i.pay_end && !rx_i.pay_abort);
  endsequence

  a_down_wake_next: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && hdr_first_i[0] && ds_low_power_i[0] |=> ds_exit_lp_o[0])
    else $error("downstream exit not started");
  a_up_wake_fwd: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && us_in_u3_i && ds_wake_start_i[0] |=> us_wake_o)
    else $error("upstream wake not forwarded");
  a_drive_wake_down: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && set_u0_req_i[0] && ds_in_u3_i[0] |=> ds_drive_wake_o[0])
    else $error("downstream wake not driven");
  a_ustate_follow: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    us_ustate_chg_o && $past(ce_i) |-> $past(|ds_ustate_chg_i))
    else $error("upstream change without cause");
  a_babble_count: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    babble_o && $past(ce_i) |-> $past(bab_cnt_q) == 11'(BABBLE_SYMBOLS - 1))
    else $error("babble at wrong count");
  a_babble_clear: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    s_pay_run |-> bab_cnt_q == 11'h000)
    else $error("babble counter not cleared");
  a_skp_spacing: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    skp_insert_o && $past(ce_i) |-> $past(skp_cnt_q) == 9'(SKP_SPACING - 1))
    else $error("skp spacing wrong");
  a_power_on_reset: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && periph_i.bus_reset |=> periph_power_on_o)
    else $error("power on late");
  a_switch_disc: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ce_i && st_q == ST_IDLE && periph_i.training && usb2_connected_i |=> usb2_disconnect_o && training_o)
    else $error("2.0 disconnect late");
  a_reset_fail_cause: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(reset_fail_o[0]) |-> $past(rst_due[0]))
    else $error("reset fail without timeout");

endmodule // hub_port_timing_limits

// ---- link_partner.sv ----
// Far-side model: received payload stream and transmit symbol strobes
`timescale 1ns/1ns
module link_partner
  import hub_timing_pkg::*;
(
  input  wire logic sys_clk_i,
  output rx_sym_s   rx_o,
  output logic      tx_symbol_o
);
  initial begin
    rx_o        = 4'h0;
    tx_symbol_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Kind 0 leaves it open, 1 ends it, 2 aborts it; idle gaps model a slow far end
  task automatic payload(input int n, input int kind, input bit start);
    @(negedge sys_clk_i);
    rx_o = start ? 4'h8 : 4'h0;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk_i);
      rx_o = 4'h1;
      if ($urandom % 4 == 0) begin
        @(negedge sys_clk_i);
        rx_o = 4'h0;
      end
    end
    @(negedge sys_clk_i);
    rx_o = (kind == 1) ? 4'h4 : (kind == 2) ? 4'h2 : 4'h0;
    @(negedge sys_clk_i);
    rx_o = 4'h0;
  endtask
  task automatic tx(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk_i);
      tx_symbol_o = 1'b1;
      if ($urandom % 3 == 0) begin
        @(negedge sys_clk_i);
        tx_symbol_o = 1'b0;
      end
    end
    @(negedge sys_clk_i);
    tx_symbol_o = 1'b0;
  endtask
endmodule // link_partner

// ---- testbench.sv ----
// Self-checking bench for the hub port timing limit block
`timescale 1ns/1ns
module testbench;
  import hub_timing_pkg::*;
  localparam int PORTS = 15;
  localparam int LIM   = 20;
  logic             sys_clk_i, arst_n_i, ce_i;
  logic [PORTS-1:0] hdr_first_i, ds_low_power_i, ds_wake_start_i, set_u0_req_i;
  logic [PORTS-1:0] ds_in_u3_i, ds_ustate_chg_i, warm_reset_i, ds_rxdetect_i;
  logic [PORTS-1:0] ds_exit_lp_o, ds_drive_wake_o, reset_fail_o, one;
  logic             us_in_u3_i, usb2_connected_i, tx_symbol_i;
  logic             us_wake_o, us_ustate_chg_o, babble_o, skp_insert_o;
  logic             periph_power_on_o, usb2_disconnect_o, training_o;
  rx_sym_s          rx_i;
  periph_ev_s       periph_i;
  logic [7:0]       ctrl_current_ma_i, ctrl_current_units_o;
  logic [15:0]      hub_delay_ns_o;
  logic [3:0]       port_count_o;
  int               miscompares, samples_checked, babble_cnt, skp_cnt, p, n, b0;
  bit               q;
  int               lens [7] = '{1030, 1029, 1031, 600, 900, 700, 1030};
  int               kinds[7] = '{0, 1, 0, 2, 0, 0, 0};
  bit               strts[7] = '{1, 1, 1, 1, 0, 1, 1};
  int               exps [7] = '{1, 0, 1, 0, 0, 0, 1};

  hub_port_timing_limits #(.PORTS(PORTS), .RESET_ERR_LIM(LIM)) i_hub_port_timing_limits (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .hdr_first_i(hdr_first_i),
    .ds_low_power_i(ds_low_power_i), .ds_wake_start_i(ds_wake_start_i), .us_in_u3_i(us_in_u3_i),
    .set_u0_req_i(set_u0_req_i), .ds_in_u3_i(ds_in_u3_i), .ds_ustate_chg_i(ds_ustate_chg_i),
    .warm_reset_i(warm_reset_i), .ds_rxdetect_i(ds_rxdetect_i), .rx_i(rx_i), .tx_symbol_i(tx_symbol_i),
    .periph_i(periph_i), .usb2_connected_i(usb2_connected_i), .ctrl_current_ma_i(ctrl_current_ma_i),
    .ds_exit_lp_o(ds_exit_lp_o), .us_wake_o(us_wake_o), .ds_drive_wake_o(ds_drive_wake_o),
    .us_ustate_chg_o(us_ustate_chg_o), .reset_fail_o(reset_fail_o), .babble_o(babble_o),
    .skp_insert_o(skp_insert_o), .periph_power_on_o(periph_power_on_o),
    .usb2_disconnect_o(usb2_disconnect_o), .training_o(training_o),
    .ctrl_current_units_o(ctrl_current_units_o), .hub_delay_ns_o(hub_delay_ns_o), .port_count_o(port_count_o));
  link_partner i_link_partner (.sys_clk_i(sys_clk_i), .rx_o(rx_i), .tx_symbol_o(tx_symbol_i));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // Pulses stand one cycle, so each is seen at exactly one edge
  always @(posedge sys_clk_i) begin
    if (babble_o === 1'b1) babble_cnt++;
    if (skp_insert_o === 1'b1) skp_cnt++;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step();
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  task automatic finish_test();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Whole run is far below this span
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hdr_first_i, ds_low_power_i, ds_wake_start_i, set_u0_req_i} = '0;
    {ds_in_u3_i, ds_ustate_chg_i, warm_reset_i, ds_rxdetect_i} = '0;
    {us_in_u3_i, usb2_connected_i} = '0;
    periph_i = 3'h0;
    ctrl_current_ma_i = 8'h00;
    arst_n_i = 1'b0;
    ce_i = 1'b1;
    void'($urandom(32'h010b));
    repeat (12) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    chk("idle", 32'h0, {reset_fail_o, babble_o, skp_insert_o, periph_power_on_o, training_o});
    chk("ports", 32'hf, port_count_o);
    chk("hub_delay", 32'h4, hub_delay_ns_o);
    // Changes land on falling edges only, clear of the sampling edge
    for (int k = 0; k < 20; k++) begin
      @(negedge sys_clk_i);
      ctrl_current_ma_i = (k == 0) ? 8'hff : 8'($urandom);
      #1;
      chk("units", ctrl_current_ma_i / 8'h04, ctrl_current_units_o);
    end
    @(negedge sys_clk_i);
    for (int k = 0; k < 200; k++) begin
      p = (k < 4) ? PORTS - 1 : $urandom % PORTS;
      q = $urandom % 2;
      one = 15'h1 << p;
      ds_low_power_i = q ? one : ~one;
      ds_in_u3_i = q ? one : ~one;
      us_in_u3_i = q;
      case (k % 4)
        0: hdr_first_i = one;
        1: ds_wake_start_i = one;
        2: set_u0_req_i = one;
        default: ds_ustate_chg_i = one;
      endcase
      step();
      {hdr_first_i, ds_wake_start_i, set_u0_req_i, ds_ustate_chg_i} = '0;
      case (k % 4)
        0: chk("exit_lp", q ? one : '0, ds_exit_lp_o);
        1: chk("us_wake", q, us_wake_o);
        2: chk("drive_wake", q ? one : '0, ds_drive_wake_o);
        default: chk("ustate", 1, us_ustate_chg_o);
      endcase
      step();
      chk("pulse_end", 0, {ds_exit_lp_o, us_wake_o, ds_drive_wake_o, us_ustate_chg_o});
    end
    // Port 0 first so the checker on that port sees a real failure
    for (int t = 0; t < 2; t++) begin
      p = (t == 0) ? 0 : $urandom % PORTS;
      one = 15'h1 << p;
      warm_reset_i = one;
      ds_rxdetect_i = one;
      // Second trial drops detect mid-count, so the limit must restart
      if (t == 1) begin
        repeat (LIM - 5) step();
        ds_rxdetect_i = '0;
        step();
        ds_rxdetect_i = one;
      end
      n = 0;
      while (reset_fail_o[p] !== 1'b1 && n < 100) begin
        step();
        n++;
      end
      chk("fail_time", 1, n == LIM || n == LIM + 1);
      repeat (3) step();
      chk("fail_hold", one, reset_fail_o);
      warm_reset_i = '0;
      ds_rxdetect_i = '0;
      step();
      chk("fail_clear", 0, reset_fail_o);
    end
    for (int k = 0; k < 7; k++) begin
      b0 = babble_cnt;
      i_link_partner.payload(lens[k], kinds[k], strts[k]);
      repeat (2) step();
      chk("babble", exps[k], babble_cnt - b0);
    end
    i_link_partner.tx(353);
    repeat (2) step();
    chk("skp", 0, skp_cnt);
    i_link_partner.tx(1);
    repeat (2) step();
    chk("skp", 1, skp_cnt);
    i_link_partner.tx(708);
    repeat (2) step();
    chk("skp", 3, skp_cnt);
    usb2_connected_i = 1'b1;
    periph_i = 3'h2;
    step();
    periph_i = 3'h0;
    chk("disc", 3, {usb2_disconnect_o, training_o});
    step();
    chk("train", 1, {usb2_disconnect_o, training_o});
    periph_i = 3'h1;
    step();
    periph_i = 3'h4;
    chk("train_end", 0, training_o);
    step();
    periph_i = 3'h0;
    chk("power_on", 1, periph_power_on_o);
    usb2_connected_i = 1'b0;
    periph_i = 3'h2;
    step();
    periph_i = 3'h0;
    chk("no_disc", 1, {usb2_disconnect_o, training_o});
    // Enable low must hold the state even with an exit event present
    ce_i = 1'b0;
    periph_i = 3'h1;
    step();
    chk("freeze", 1, training_o);
    ce_i = 1'b1;
    step();
    periph_i = 3'h0;
    chk("thaw", 0, training_o);
    finish_test();
  end
endmodule // testbench
